// File: rtl/pai_regs.svh
// Register offsets, field positions, reset values and timing counts of the PCM audio link
`ifndef PAI_REGS_SVH
`define PAI_REGS_SVH

// ==========================================================================
// Receiver registers
`define PAI_REG_FORMAT 4'h2
`define PAI_REG_PATH 4'h3
`define PAI_REG_PAIR_COUNT 4'h4
`define PAI_REG_ACTIVE 4'h5
`define PAI_FORMAT_RESET 8'h00
`define PAI_PATH_RESET 8'h00
`define PAI_FORMAT_MASK 8'h1F
`define PAI_PATH_MASK 8'hC0

// ==========================================================================
// Field positions
`define PAI_WL_MSB 1
`define PAI_WL_LSB 0
`define PAI_FMT_MSB 3
`define PAI_FMT_LSB 2
`define PAI_LRP_BIT 4
`define PAI_BCP_BIT 6
`define PAI_REV_BIT 7
`define PAI_EN_BIT 7

// ==========================================================================
// Source controller registers
`define PAI_SRC_CTRL 4'h0
`define PAI_SRC_LEFT 4'h1
`define PAI_SRC_RIGHT 4'h2
`define PAI_SRC_STATUS 4'h3
`define PAI_SRC_CTRL_RESET 8'h00
`define PAI_SRC_CTRL_MASK 8'hDF

// ==========================================================================
// Timing and sizes
`define PAI_SYS_CLK_NS 4
`define PAI_SRC_BCK_PERIOD_NS 128
`define PAI_SRC_BCK_HALF (`PAI_SRC_BCK_PERIOD_NS / (2 * `PAI_SYS_CLK_NS))
`define PAI_FIFO_DEPTH 4
`define PAI_FRAME_LAST 6'h3F

`endif

// File: rtl/pai_pkg.sv
// Types and shared decode functions of the PCM audio link
package pai_pkg;

  // ========================================================================
  // Types
  typedef enum logic [1:0] {PAI_FMT_RJ, PAI_FMT_LJ, PAI_FMT_I2S, PAI_FMT_DSP} pai_fmt_t;
  typedef enum logic {PAI_SRC_IDLE, PAI_SRC_RUN} pai_src_state_t;

  // ========================================================================
  // Decode
  function automatic logic [6:0] pai_wl_bits(input logic [1:0] wl);
    case (wl)
      2'h0: return 7'h10;
      2'h1: return 7'h14;
      2'h2: return 7'h18;
      default: return 7'h20;
    endcase
  endfunction : pai_wl_bits

  // Received word sits in the low bits; result is MSB aligned, zero filled below
  function automatic logic [23:0] pai_align(input logic [31:0] w, input logic [1:0] wl);
    case (wl)
      2'h0: return {w[15:0], 8'h00};
      2'h1: return {w[19:0], 4'h0};
      2'h2: return w[23:0];
      default: return w[31:8];
    endcase
  endfunction : pai_align

endpackage : pai_pkg

// File: rtl/pai_link_if.sv
// Serial PCM link between the audio source and the receiver
`timescale 1ns/10ps
interface pai_link_if;
  logic bck;
  logic lrc;
  logic sdata;
  modport source (output bck, output lrc, output sdata);
  modport sink (input bck, input lrc, input sdata);
endinterface : pai_link_if

// File: rtl/pai_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module pai_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  // DEPTH must be a power of two so the pointers wrap on their own
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = count != CW'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign level = count;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop) rd_ptr <= rd_ptr + AW'(1);
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule : pai_fifo

// File: rtl/pai_source.sv
// Audio source end: queues sample pairs and drives the serial PCM link
`include "pai_regs.svh"
`timescale 1ns/10ps
module pai_source import pai_pkg::*; #(
  parameter int BCK_HALF = `PAI_SRC_BCK_HALF
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  pai_link_if.source LINK,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA
);
  // ========================================================================
  // Registers and queue
  logic [7:0] ctrl;
  logic [31:0] left_stage;
  logic overflow;
  logic underrun;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [63:0] fifo_out_data;
  logic [2:0] fifo_level;
  wire wr_ctrl = REG_WR && REG_ADDR == `PAI_SRC_CTRL;
  wire push = REG_WR && REG_ADDR == `PAI_SRC_RIGHT;
  wire rd_status = REG_RD && REG_ADDR == `PAI_SRC_STATUS;
  // Right justified with 32-bit words is never programmed
  wire ctrl_ok = !(REG_WDATA[`PAI_FMT_MSB:`PAI_FMT_LSB] == 2'h0 && REG_WDATA[`PAI_WL_MSB:`PAI_WL_LSB] == 2'h3);

  // ========================================================================
  // Bit clock divider and frame position
  pai_src_state_t state;
  logic [7:0] div_cnt;
  logic [5:0] pos;
  logic bck;
  logic lrc;
  logic sdata;
  pai_fmt_t act_fmt;
  logic [1:0] act_wl;
  logic act_lrp;
  logic act_bcp;
  logic [31:0] frame_l;
  logic [31:0] frame_r;
  wire toggle = state == PAI_SRC_RUN && div_cnt == 8'(BCK_HALF - 1);
  // Data and frame select change on the edge opposite to the sampling one
  wire launch = toggle && (~bck == act_bcp);
  wire frame_start = launch && pos == 6'h00;
  wire stop = frame_start && !ctrl[`PAI_EN_BIT];
  wire pop = frame_start && !stop;
  wire [31:0] load_l = fifo_out_valid ? fifo_out_data[63:32] : 32'h0;
  wire [31:0] load_r = fifo_out_valid ? fifo_out_data[31:0] : 32'h0;
  // A new frame picks up its format only at its own start
  wire pai_fmt_t cur_fmt = frame_start ? pai_fmt_t'(ctrl[`PAI_FMT_MSB:`PAI_FMT_LSB]) : act_fmt;
  wire [1:0] cur_wl = frame_start ? ctrl[`PAI_WL_MSB:`PAI_WL_LSB] : act_wl;
  wire cur_lrp = frame_start ? ctrl[`PAI_LRP_BIT] : act_lrp;
  wire [31:0] cur_l = frame_start ? load_l : frame_l;
  wire [31:0] cur_r = frame_start ? load_r : frame_r;

  // ========================================================================
  // Bit selection, MSB first
  wire [7:0] wl8 = {1'b0, pai_wl_bits(cur_wl)};
  wire [7:0] k = {3'h0, pos[4:0]};
  wire [7:0] d_dsp = {2'h0, pos} - {7'h00, cur_lrp};
  // A 32-bit I2S word spills its last bit into the first edge of the next slot
  wire i2s_wrap = cur_fmt == PAI_FMT_I2S && pos[4:0] == 5'h00;
  wire [7:0] d_i2s = i2s_wrap ? 8'h1F : k - 8'h01;
  wire [7:0] d_slot = cur_fmt == PAI_FMT_LJ ? k : cur_fmt == PAI_FMT_I2S ? d_i2s : k + wl8 - 8'h20;
  wire dsp_second = cur_fmt == PAI_FMT_DSP && d_dsp >= wl8 && !d_dsp[7];
  // Right word follows the left one with no spare edges
  wire [7:0] d = cur_fmt == PAI_FMT_DSP ? (dsp_second ? d_dsp - wl8 : d_dsp) : d_slot;
  wire [31:0] prev_word = pos[5] ? cur_l : frame_r;
  wire [31:0] slot_word = (cur_fmt == PAI_FMT_DSP ? dsp_second : pos[5]) ? cur_r : cur_l;
  wire [31:0] word = i2s_wrap ? prev_word : slot_word;
  wire bit_valid = !d[7] && d < wl8;
  wire next_sdata = bit_valid && word[5'd31 - d[4:0]];
  wire slot_lrc = (pos[5] ^ (cur_fmt != PAI_FMT_I2S)) ^ cur_lrp;
  wire next_lrc = cur_fmt == PAI_FMT_DSP ? pos == 6'h00 : slot_lrc;

  pai_fifo #(.WIDTH(64), .DEPTH(`PAI_FIFO_DEPTH)) u_fifo (
    .clk(SYS_CLK),
    .rst(RST),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({left_stage, REG_WDATA}),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  assign LINK.bck = bck;
  assign LINK.lrc = lrc;
  assign LINK.sdata = sdata;

  wire [31:0] status = {25'h0, fifo_level, underrun, overflow, !fifo_out_valid, !fifo_in_ready};

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctrl <= `PAI_SRC_CTRL_RESET;
      left_stage <= 32'h0;
      overflow <= 1'b0;
      underrun <= 1'b0;
      REG_RDATA <= 32'h0;
    end else begin
      if (wr_ctrl && ctrl_ok) ctrl <= REG_WDATA[7:0] & `PAI_SRC_CTRL_MASK;
      if (REG_WR && REG_ADDR == `PAI_SRC_LEFT) left_stage <= REG_WDATA;
      // Setting beats the clear done by reading status
      overflow <= (push && !fifo_in_ready) || (overflow && !rd_status);
      underrun <= (pop && !fifo_out_valid) || (underrun && !rd_status);
      REG_RDATA <= !REG_RD ? 32'h0 : REG_ADDR == `PAI_SRC_CTRL ? {24'h0, ctrl} :
                   REG_ADDR == `PAI_SRC_LEFT ? left_stage : rd_status ? status : 32'h0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state <= PAI_SRC_IDLE;
      div_cnt <= 8'h00;
      pos <= 6'h00;
      bck <= 1'b1;
      lrc <= 1'b0;
      sdata <= 1'b0;
      act_bcp <= 1'b0;
    end else if (state == PAI_SRC_IDLE) begin
      bck <= ~ctrl[`PAI_BCP_BIT];
      div_cnt <= 8'h00;
      pos <= 6'h00;
      act_bcp <= ctrl[`PAI_BCP_BIT];
      if (ctrl[`PAI_EN_BIT]) state <= PAI_SRC_RUN;
    end else begin
      div_cnt <= toggle ? 8'h00 : div_cnt + 8'h01;
      if (stop) begin
        state <= PAI_SRC_IDLE;
      end else if (toggle) begin
        bck <= ~bck;
      end
      if (launch && !stop) begin
        pos <= pos + 6'h01;
        sdata <= next_sdata;
        lrc <= next_lrc;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      act_fmt <= PAI_FMT_RJ;
      act_wl <= 2'h0;
      act_lrp <= 1'b0;
      frame_l <= 32'h0;
      frame_r <= 32'h0;
    end else if (pop) begin
      act_fmt <= cur_fmt;
      act_wl <= cur_wl;
      act_lrp <= cur_lrp;
      frame_l <= load_l;
      frame_r <= load_r;
    end
  end
endmodule : pai_source

// File: rtl/pai_receiver.sv
// Receiver end: decodes the serial PCM link into 24-bit left/right sample pairs
//
// Overview of operation
// - Phase bit 7 inverts output sign
// - Word length 1:0, format 3:2, reset zero
// - Format code picks RJ, LJ, I2S, DSP
// - Length code picks 16, 20, 24, 32
// - Source never programs 32-bit right justified
// - Samples are signed two's complement
// - Short words zero padded to 24 bits
// - 32-bit words drop lowest eight bits
// - Sample on rising edge unless inverted
// - Frame polarity bit flips channel levels, except in DSP
// - DSP early takes first bit on rise
// - DSP right word follows left directly
`include "pai_regs.svh"
`timescale 1ns/10ps
module pai_receiver import pai_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RST,
  pai_link_if.sink LINK,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic [23:0] SAMPLE_LEFT,
  output logic [23:0] SAMPLE_RIGHT,
  output logic SAMPLE_VALID
);
  // ========================================================================
  // Control registers
  logic [7:0] format_ctrl;
  logic [7:0] path_ctrl;
  logic [7:0] pair_count;
  wire wr_format = REG_WR && REG_ADDR == `PAI_REG_FORMAT;
  wire wr_path = REG_WR && REG_ADDR == `PAI_REG_PATH;
  wire bck_invert = path_ctrl[`PAI_BCP_BIT];
  wire phase_invert = path_ctrl[`PAI_REV_BIT];

  // ========================================================================
  // Pin synchronisers
  logic [2:0] bck_sync;
  logic [1:0] lrc_sync;
  logic [1:0] din_sync;

  // ========================================================================
  // Frame decoder state
  pai_fmt_t act_fmt;
  logic [1:0] act_wl;
  logic act_lrp;
  logic [31:0] sr;
  logic [6:0] cnt;
  logic prev_right;
  logic prev_lrc;
  logic [23:0] left_hold;
  logic have_left;

  logic [31:0] next_sr;
  logic [6:0] next_cnt;
  logic shifted;
  logic frame_start;
  logic store_left;
  logic store_right;
  logic [23:0] store_word;

  // ========================================================================
  // Edge and level decode
  wire bck_now = bck_sync[1];
  wire bck_old = bck_sync[2];
  wire lrc_raw = lrc_sync[1];
  wire din = din_sync[1];
  // Sampling edge is rising by default, falling when the edge sense is inverted
  wire sample_edge = (bck_now != bck_old) && (bck_now != bck_invert);
  wire dsp_mode = act_fmt == PAI_FMT_DSP;
  wire rj_mode = act_fmt == PAI_FMT_RJ;
  wire lrc_level = lrc_raw ^ (!dsp_mode && act_lrp);
  // I2S marks the left slot with a low level, the justified framings with a high one
  wire is_right = act_fmt == PAI_FMT_I2S ? lrc_level : ~lrc_level;
  wire slot_change = is_right != prev_right;
  wire dsp_rise = lrc_raw && !prev_lrc;
  wire [6:0] wl_bits = pai_wl_bits(act_wl);
  wire [6:0] wl2_bits = {wl_bits[5:0], 1'b0};
  // MSB arrives first, so each new bit enters at the bottom
  wire [31:0] sr_shift = {sr[30:0], din};

  // ========================================================================
  // Slot sequencing
  always_comb begin
    next_sr = sr;
    next_cnt = cnt;
    shifted = 1'b0;
    frame_start = 1'b0;
    store_left = 1'b0;
    store_right = 1'b0;
    store_word = pai_align(sr_shift, act_wl);
    if (sample_edge) begin
      if (dsp_mode) begin
        if (dsp_rise) begin
          frame_start = 1'b1;
          // Early mode takes the bit on the very edge that sees the rise
          shifted = !act_lrp;
          next_cnt = act_lrp ? 7'h00 : 7'h01;
        end else if (cnt < wl2_bits) begin
          // Right word bits continue straight after the left word
          shifted = 1'b1;
          next_cnt = cnt + 7'h01;
        end
      end else if (rj_mode) begin
        // The word ends on the last bit before the slot change
        next_sr = sr_shift;
        if (slot_change) begin
          store_word = pai_align(sr, act_wl);
          store_left = !prev_right;
          store_right = prev_right;
          frame_start = !is_right;
        end
      end else if (slot_change) begin
        frame_start = !is_right;
        // Left justified data starts on the change, I2S one bit later
        shifted = act_fmt == PAI_FMT_LJ;
        next_cnt = shifted ? 7'h01 : 7'h00;
        // A full 32-bit I2S word ends on the edge that already shows the next slot
        if (act_fmt == PAI_FMT_I2S && cnt == wl_bits - 7'h01) begin
          next_sr = sr_shift;
          store_left = !prev_right;
          store_right = prev_right;
        end
      end else if (cnt < wl_bits) begin
        // Bits beyond the word length within a slot are ignored
        shifted = 1'b1;
        next_cnt = cnt + 7'h01;
      end
      if (shifted) begin
        next_sr = sr_shift;
        if (next_cnt == wl_bits) begin
          store_left = dsp_mode || !is_right;
          store_right = !dsp_mode && is_right;
        end else if (dsp_mode && next_cnt == wl2_bits) begin
          store_right = 1'b1;
        end
      end
    end
  end

  // ========================================================================
  // Output conversion
  // Negating the most negative code would wrap, so it saturates instead
  function automatic logic [23:0] pai_phase(input logic [23:0] s, input logic inv);
    if (!inv) begin
      return s;
    end
    if (s == 24'h800000) begin
      return 24'h7FFFFF;
    end
    return ~s + 24'h000001;
  endfunction : pai_phase

  wire [23:0] out_left = pai_phase(left_hold, phase_invert);
  wire [23:0] out_right = pai_phase(store_word, phase_invert);
  wire pair_done = store_right && have_left;
  wire [7:0] active_view = {3'h0, act_lrp, act_fmt, act_wl};
  wire [7:0] read_mux = REG_ADDR == `PAI_REG_FORMAT ? format_ctrl :
                        REG_ADDR == `PAI_REG_PATH ? path_ctrl :
                        REG_ADDR == `PAI_REG_PAIR_COUNT ? pair_count :
                        REG_ADDR == `PAI_REG_ACTIVE ? active_view : 8'h00;

  // ========================================================================
  // Register port
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      format_ctrl <= `PAI_FORMAT_RESET;
      path_ctrl <= `PAI_PATH_RESET;
      REG_RDATA <= 8'h00;
    end else begin
      if (wr_format) format_ctrl <= REG_WDATA & `PAI_FORMAT_MASK;
      if (wr_path) path_ctrl <= REG_WDATA & `PAI_PATH_MASK;
      REG_RDATA <= REG_RD ? read_mux : 8'h00;
    end
  end

  // ========================================================================
  // Synchronisers: first stage feeds only the second
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      // Matches the idle bit clock level so leaving reset makes no false edge
      bck_sync <= 3'h7;
      lrc_sync <= 2'h0;
      din_sync <= 2'h0;
    end else begin
      bck_sync <= {bck_sync[1:0], LINK.bck};
      lrc_sync <= {lrc_sync[0], LINK.lrc};
      din_sync <= {din_sync[0], LINK.sdata};
    end
  end

  // ========================================================================
  // Decoder state
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sr <= 32'h0;
      // Idle until the first slot boundary so no stray bits are taken
      cnt <= 7'h7F;
      prev_right <= 1'b0;
      prev_lrc <= 1'b0;
    end else begin
      sr <= next_sr;
      cnt <= next_cnt;
      if (sample_edge) begin
        prev_right <= is_right;
        prev_lrc <= lrc_raw;
      end
    end
  end

  // New format and length apply from the frame boundary onward
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      act_fmt <= PAI_FMT_RJ;
      act_wl <= 2'h0;
      act_lrp <= 1'b0;
    end else if (frame_start) begin
      act_fmt <= pai_fmt_t'(format_ctrl[`PAI_FMT_MSB:`PAI_FMT_LSB]);
      act_wl <= format_ctrl[`PAI_WL_MSB:`PAI_WL_LSB];
      act_lrp <= format_ctrl[`PAI_LRP_BIT];
    end
  end

  // ========================================================================
  // Pair hand-off
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      left_hold <= 24'h0;
      have_left <= 1'b0;
      SAMPLE_LEFT <= 24'h0;
      SAMPLE_RIGHT <= 24'h0;
      SAMPLE_VALID <= 1'b0;
      pair_count <= 8'h00;
    end else begin
      SAMPLE_VALID <= pair_done;
      if (store_left) begin
        left_hold <= store_word;
        have_left <= 1'b1;
      end else if (store_right) begin
        // A right word with no left before it is dropped
        have_left <= 1'b0;
      end
      if (pair_done) begin
        SAMPLE_LEFT <= out_left;
        SAMPLE_RIGHT <= out_right;
        pair_count <= pair_count + 8'h01;
      end
    end
  end
endmodule : pai_receiver

// File: testbench/pai_link_sva.sv
// Checker of the serial link and sample pulses between source and receiver
`timescale 1ns/10ps
module pai_link_sva #(
  parameter int BCK_HALF = 4
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic bck,
  input wire logic lrc,
  input wire logic sdata,
  input wire logic SAMPLE_VALID
);
  // ==========================================================================
  // Helper counters
  logic bck_q;
  logic lrc_q;
  logic clean;
  logic [7:0] gap;
  logic [7:0] hi_cnt;
  logic [7:0] vgap;
  wire logic bck_chg = bck ^ bck_q;
  wire logic lrc_chg = lrc ^ lrc_q;
  // A long stall means the source stopped, so run lengths start afresh
  wire logic stalled = gap == 8'hFF;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      bck_q <= 1'b1;
      lrc_q <= 1'b0;
      clean <= 1'b0;
      gap <= 8'hFF;
      hi_cnt <= 8'h00;
      vgap <= 8'hFF;
    end else begin
      bck_q <= bck;
      lrc_q <= lrc;
      clean <= !stalled && (clean || (lrc && !lrc_q));
      gap <= bck_chg ? 8'h00 : gap + {7'h00, !stalled};
      hi_cnt <= lrc_chg ? 8'h00 : hi_cnt + {7'h00, bck_chg};
      vgap <= SAMPLE_VALID ? 8'h00 : vgap + {7'h00, vgap != 8'hFF};
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  sequence s_pulse;
    SAMPLE_VALID ##1 !SAMPLE_VALID;
  endsequence
  sequence s_high_end;
    lrc_q && !lrc && clean;
  endsequence

  AST_BCK_MIN: assert property (bck_chg |-> gap >= BCK_HALF - 1)
    else $error("bck half period too short");
  AST_BCK_EXACT: assert property (bck_chg && gap < 2 * BCK_HALF |-> gap == BCK_HALF - 1)
    else $error("bck half period uneven");
  AST_LRC_EDGE: assert property (lrc_chg |-> bck_chg)
    else $error("lrc moved off a bck edge");
  AST_DATA_EDGE: assert property ($changed(sdata) |-> bck_chg)
    else $error("sdata moved off a bck edge");
  AST_VALID_PULSE: assert property (SAMPLE_VALID |-> s_pulse)
    else $error("sample valid longer than one cycle");
  AST_VALID_SPACING: assert property (SAMPLE_VALID |-> vgap >= 8'h64)
    else $error("two pairs within one frame");
  AST_VALID_LIVE: assert property (SAMPLE_VALID |-> gap < 2 * BCK_HALF + 8)
    else $error("pair with no recent bck edge");
  AST_LRC_RUN: assert property (s_high_end |-> hi_cnt inside {8'h01, 8'h3F, 8'h41, 8'h7F})
    else $error("lrc high run has wrong length");
endmodule : pai_link_sva

// File: testbench/pcm_audio_input_format_decoder_test.sv
// Self-checking bench: source and receiver joined over the serial link
`timescale 1ns/10ps
module pcm_audio_input_format_decoder_test;
  localparam int HALF = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] s_addr = 4'h0;
  logic [31:0] s_wdata = 32'h0;
  logic s_wr = 1'b0;
  logic s_rd = 1'b0;
  logic [31:0] s_rdata;
  logic [3:0] r_addr = 4'h0;
  logic [7:0] r_wdata = 8'h0;
  logic r_wr = 1'b0;
  logic r_rd = 1'b0;
  logic [7:0] r_rdata;
  logic [23:0] s_left;
  logic [23:0] s_right;
  logic s_valid;
  logic [31:0] st = 32'hE07FF085;
  int fails = 0;
  int tests_run = 0;

  always #2 clk = ~clk;

  pai_link_if pai_link_if_i();
  pai_source #(.BCK_HALF(HALF)) pai_source_i (.SYS_CLK(clk), .RST(rst), .LINK(pai_link_if_i),
    .REG_ADDR(s_addr), .REG_WDATA(s_wdata), .REG_WR(s_wr), .REG_RD(s_rd), .REG_RDATA(s_rdata));
  pai_receiver pai_receiver_i (.SYS_CLK(clk), .RST(rst), .LINK(pai_link_if_i), .REG_ADDR(r_addr),
    .REG_WDATA(r_wdata), .REG_WR(r_wr), .REG_RD(r_rd), .REG_RDATA(r_rdata), .SAMPLE_LEFT(s_left),
    .SAMPLE_RIGHT(s_right), .SAMPLE_VALID(s_valid));
  pai_link_sva #(.BCK_HALF(HALF)) pai_link_sva_i (.SYS_CLK(clk), .RST(rst), .bck(pai_link_if_i.bck),
    .lrc(pai_link_if_i.lrc), .sdata(pai_link_if_i.sdata), .SAMPLE_VALID(s_valid));

  // ==========================================================================
  // Helpers
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    // Keeps the top 16 bits nonzero so a real pair never looks like a silent frame
    return st | 32'h00010000;
  endfunction : xs

  // Word arrives MSB aligned; the receiver keeps the top bits, zero below
  function automatic logic [23:0] expv(input logic [31:0] w, input logic [1:0] wl, input bit inv);
    logic [23:0] v;
    v = w[31:8] & (24'hFFFFFF << (wl == 2'h0 ? 8 : (wl == 2'h1 ? 4 : 0)));
    if (inv) begin
      v = (v == 24'h800000) ? 24'h7FFFFF : -v;
    end
    return v;
  endfunction : expv

  task automatic acc(input bit rx, input bit w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    if (rx) begin
      {r_addr, r_wdata, r_wr, r_rd} <= {a, d[7:0], w, !w};
    end else begin
      {s_addr, s_wdata, s_wr, s_rd} <= {a, d, w, !w};
    end
    @(posedge clk);
    {r_wr, r_rd, s_wr, s_rd} <= 4'h0;
    #1 q = rx ? {24'h0, r_rdata} : s_rdata;
  endtask : acc

  task automatic wr(input bit rx, input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(rx, 1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input bit rx, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(rx, 1'b0, a, 32'h0, q);
    check(q, e);
  endtask : rdc

  task automatic get_pair(output logic [23:0] l, output logic [23:0] r);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      #1;
      if (s_valid === 1'b1 && {s_left, s_right} !== 48'h0) break;
    end
    l = s_left;
    r = s_right;
    if (n == 3000) begin
      fails++;
      end_of_test();
    end
  endtask : get_pair

  task automatic pair_test(input logic [31:0] a, input logic [31:0] b, input logic [1:0] wl, input bit inv);
    logic [23:0] l;
    logic [23:0] r;
    wr(0, 4'h1, a);
    wr(0, 4'h2, b);
    get_pair(l, r);
    check({8'h0, l}, {8'h0, expv(a, wl, inv)});
    check({8'h0, r}, {8'h0, expv(b, wl, inv)});
  endtask : pair_test

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] pl [5];
    logic [31:0] pr [5];
    logic [23:0] l;
    logic [23:0] r;
    bit frame_select_polarity;
    bit inv;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(1, 4'h2, 32'h0);
    rdc(1, 4'h3, 32'h0);
    rdc(0, 4'h0, 32'h0);
    wr(1, 4'h2, 32'hFF);
    rdc(1, 4'h2, 32'h1F);
    wr(1, 4'h3, 32'hFF);
    rdc(1, 4'h3, 32'hC0);
    rdc(1, 4'h7, 32'h0);
    wr(1, 4'h2, 32'h0);
    wr(1, 4'h3, 32'h0);
    wr(0, 4'h0, 32'h03);
    rdc(0, 4'h0, 32'h0);
    // Fill the stopped source past full, then drain it at reset format
    for (int i = 0; i < 5; i++) begin
      pl[i] = xs();
      pr[i] = xs();
      wr(0, 4'h1, pl[i]);
      wr(0, 4'h2, pr[i]);
    end
    rdc(0, 4'h3, 32'h45);
    rdc(0, 4'h3, 32'h41);
    wr(0, 4'h0, 32'h80);
    for (int i = 0; i < 4; i++) begin
      get_pair(l, r);
      check({8'h0, l}, {8'h0, expv(pl[i], 2'h0, 1'b0)});
      check({8'h0, r}, {8'h0, expv(pr[i], 2'h0, 1'b0)});
    end
    repeat (600) @(posedge clk);
    rdc(0, 4'h3, 32'h0A);
    for (int f = 0; f < 4; f++) begin
      for (int w = 0; w < 4; w++) begin
        if (f == 0 && w == 3) continue;
        frame_select_polarity = f[0] ^ w[0];
        inv = f[1] ^ w[0];
        wr(1, 4'h2, {27'h0, frame_select_polarity, f[1:0], w[1:0]});
        wr(1, 4'h3, {24'h0, inv, 7'h0});
        wr(0, 4'h0, {24'h0, 3'h4, frame_select_polarity, f[1:0], w[1:0]});
        repeat (1100) @(posedge clk);
        rdc(1, 4'h5, {27'h0, frame_select_polarity, f[1:0], w[1:0]});
        pair_test(xs(), xs(), w[1:0], inv);
      end
    end
    // Falling-edge sampling on both ends, with the full-scale corner inverted
    wr(0, 4'h0, 32'h0);
    repeat (1100) @(posedge clk);
    wr(1, 4'h2, 32'h06);
    wr(1, 4'h3, 32'hC0);
    wr(0, 4'h0, 32'hC6);
    repeat (1100) @(posedge clk);
    pair_test(32'h80000000, 32'h7FFFFF00, 2'h2, 1'b1);
    end_of_test();
  end
endmodule : pcm_audio_input_format_decoder_test
